// ==== hw/baud_timer_pkg.sv ====
// constants for the fractional uart baud timer
// assumes one 125 MHz clock and an apb slave port
package baud_timer_pkg;

	// ------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------
	localparam logic [7:0] ctrl_offset   = 8'h00;
	localparam logic [7:0] fdv_offset    = 8'h04;
	localparam logic [7:0] clkctl_offset = 8'h08;
	localparam logic [7:0] status_offset = 8'h0C;

	// ------------------------------------------------
	// fields and reset values
	// ------------------------------------------------
	localparam int         select_bit        = 7;
	localparam int         exp_msb           = 2;
	localparam int         status_select_bit = 16;
	localparam logic [7:0] ctrl_write_mask   = 8'h87;
	localparam logic [7:0] ctrl_reset        = 8'h00;
	localparam logic [7:0] fdv_reset         = 8'h00;
	localparam logic [2:0] clkctl_reset      = 3'h0;

	// ------------------------------------------------
	// divider figures
	// ------------------------------------------------
	localparam logic [8:0] fd_base      = 9'h040;
	localparam logic [8:0] acc_step     = 9'h002;
	localparam logic [4:0] t1_last_one  = 5'h1F;
	localparam logic [4:0] t1_last_two  = 5'h0F;
	localparam logic [3:0] t2_last      = 4'hF;

	// 2^e - 1, used by both the core and the exponent prescalers
	function automatic logic [6:0] pow2_mask(input logic [2:0] e);
		logic [7:0] one;
		one = 8'h01 << e;
		return 7'(one - 8'h01);
	endfunction

endpackage

// ==== hw/uart_fractional_baud_timer.sv ====
// fractional baud rate generator for the serial port
// assumes an apb master on clk and classic timer overflow pulses
//
// How it works
// - select bit 7 of control makes this timer the uart rate source.
// - while selected, rate doubling and timer2 clock selects are ignored.
// - select clear passes the classic timer1/timer2 rates through unchanged.
// - control bits 2:0 set a power-of-two prescale of the core clock.
// - rate is 2*fcore / (2^exp * (fractional value + 64)).
// - core clock is clk divided by 2 to the power of the core divide setting.
// - at 125 MHz, any rate 48 to 3906250 bit/s within 0.8 percent is reachable.
// - this timer runs apart from the general timers.
// - classic path: rate doubling halves the timer1 overflow divide.
//
// Implementation choices: the APB slave port and the address map.
module uart_fractional_baud_timer (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer1_overflow,
	input  wire logic        timer2_overflow,
	input  wire logic        rate_double_bit,
	input  wire logic        timer2_tx_clk_sel,
	input  wire logic        timer2_rx_clk_sel,
	output logic             tx_bit_tick,
	output logic             rx_bit_tick,
	output logic             baud_timer_select
);
	import baud_timer_pkg::*;

	// ------------------------------------------------
	// registers and internal state
	// ------------------------------------------------
	logic [7:0] baud_timer_control;
	logic [7:0] fractional_divide_value;
	logic [2:0] core_divide_setting;
	logic [6:0] core_cnt;
	logic [6:0] pre_cnt;
	logic [8:0] acc;
	logic [4:0] t1_cnt;
	logic [3:0] t2_cnt;
	logic       wr;
	logic       setup;
	logic       cfg_write;
	logic       clk_write;
	logic       core_tick;
	logic       pre_tick;
	logic       t3_tick;
	logic       t1_tick;
	logic       t2_tick;
	logic       classic_tx;
	logic       classic_rx;
	logic [2:0] exponent;
	logic [8:0] limit;
	logic [8:0] acc_sum;
	logic       sel;

	// ------------------------------------------------
	// apb slave
	// ------------------------------------------------
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr     = psel & penable & pwrite;
	assign setup  = psel & ~penable;

	assign clk_write = wr & (paddr == clkctl_offset);
	assign cfg_write = wr & ((paddr == ctrl_offset) | (paddr == fdv_offset) | clk_write);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_timer_control <= ctrl_reset;
		end else if (wr && paddr == ctrl_offset) begin
			baud_timer_control <= pwdata[7:0] & ctrl_write_mask;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fractional_divide_value <= fdv_reset;
		end else if (wr && paddr == fdv_offset) begin
			fractional_divide_value <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_divide_setting <= clkctl_reset;
		end else if (clk_write) begin
			core_divide_setting <= pwdata[2:0];
		end
	end

	// read data is captured in the setup cycle so it comes from flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			unique case (paddr)
				ctrl_offset:   prdata <= {24'h00_0000, baud_timer_control};
				fdv_offset:    prdata <= {24'h00_0000, fractional_divide_value};
				clkctl_offset: prdata <= {29'h0000_0000, core_divide_setting};
				status_offset: begin
					prdata[8:0]               <= acc;
					prdata[status_select_bit] <= sel;
				end
				default:       pslverr <= 1'b1;
			endcase
		end
	end

	// ------------------------------------------------
	// core clock enable
	// ------------------------------------------------
	assign core_tick = (core_cnt == pow2_mask(core_divide_setting));

	// a new divide setting restarts the count, so no long wrap occurs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_cnt <= 7'h00;
		end else if (clk_write || core_tick) begin
			core_cnt <= 7'h00;
		end else begin
			core_cnt <= core_cnt + 7'h01;
		end
	end

	// ------------------------------------------------
	// exponent prescaler
	// ------------------------------------------------
	assign sel      = baud_timer_control[select_bit];
	assign exponent = baud_timer_control[exp_msb:0];
	assign pre_tick = core_tick & (pre_cnt == pow2_mask(exponent));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt <= 7'h00;
		end else if (cfg_write) begin
			pre_cnt <= 7'h00;
		end else if (pre_tick) begin
			pre_cnt <= 7'h00;
		end else if (core_tick) begin
			pre_cnt <= pre_cnt + 7'h01;
		end
	end

	// ------------------------------------------------
	// fractional divider
	// ------------------------------------------------
	// adding 2 per prescaled tick against (value+64) gives the exact
	// average rate; the step never reaches the limit, so one tick at most
	assign limit   = {1'b0, fractional_divide_value} + fd_base;
	assign acc_sum = acc + acc_step;
	assign t3_tick = pre_tick & (acc_sum >= limit);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc <= 9'h000;
		end else if (cfg_write) begin
			acc <= 9'h000;
		end else if (t3_tick) begin
			acc <= acc_sum - limit;
		end else if (pre_tick) begin
			acc <= acc_sum;
		end
	end

	// ------------------------------------------------
	// classic timer rates
	// ------------------------------------------------
	assign t1_tick = timer1_overflow & (t1_cnt >= (rate_double_bit ? t1_last_two : t1_last_one));
	assign t2_tick = timer2_overflow & (t2_cnt == t2_last);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			t1_cnt <= 5'h00;
		end else if (t1_tick) begin
			t1_cnt <= 5'h00;
		end else if (timer1_overflow) begin
			t1_cnt <= t1_cnt + 5'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			t2_cnt <= 4'h0;
		end else if (timer2_overflow) begin
			t2_cnt <= t2_cnt + 4'h1;
		end
	end

	assign classic_tx = timer2_tx_clk_sel ? t2_tick : t1_tick;
	assign classic_rx = timer2_rx_clk_sel ? t2_tick : t1_tick;

	// ------------------------------------------------
	// rate source select
	// ------------------------------------------------
	// the fractional path reads none of the timer inputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_bit_tick       <= 1'b0;
			rx_bit_tick       <= 1'b0;
			baud_timer_select <= 1'b0;
		end else begin
			tx_bit_tick       <= sel ? t3_tick : classic_tx;
			rx_bit_tick       <= sel ? t3_tick : classic_rx;
			baud_timer_select <= sel;
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	chk_select_drives_tick: assert property (
		@(posedge clk) disable iff (!reset_n)
		sel && t3_tick |=> tx_bit_tick && rx_bit_tick)
		else $error("fractional tick not passed to uart");

	chk_classic_ignored: assert property (
		@(posedge clk) disable iff (!reset_n)
		sel && !t3_tick && (t1_tick || t2_tick) |=> !tx_bit_tick && !rx_bit_tick)
		else $error("classic tick leaked while selected");

	chk_classic_passthru: assert property (
		@(posedge clk) disable iff (!reset_n)
		!sel |=> tx_bit_tick == $past(classic_tx) && rx_bit_tick == $past(classic_rx))
		else $error("classic rate altered");

	chk_prescale_period: assert property (
		@(posedge clk) disable iff (!reset_n)
		pre_tick && !cfg_write && exponent == 3'h1 && core_divide_setting == 3'h0 ##1 !cfg_write
		|-> !pre_tick ##1 pre_tick)
		else $error("prescale by two wrong");

	chk_fraction_step: assert property (
		@(posedge clk) disable iff (!reset_n)
		pre_tick && !cfg_write |=> acc + ($past(t3_tick) ? $past(limit) : 9'h000) == $past(acc) + acc_step)
		else $error("fractional step wrong");

	chk_core_period: assert property (
		@(posedge clk) disable iff (!reset_n)
		core_tick && !clk_write && core_divide_setting == 3'h1 ##1 !clk_write
		|-> !core_tick ##1 core_tick)
		else $error("core divide by two wrong");

	chk_acc_bound: assert property (
		@(posedge clk) disable iff (!reset_n)
		acc < limit || $past(cfg_write))
		else $error("accumulator above limit");

	chk_timers_independent: assert property (
		@(posedge clk) disable iff (!reset_n)
		sel && !t3_tick |=> !tx_bit_tick)
		else $error("tick without fractional cause");

	chk_double_rate: assert property (
		@(posedge clk) disable iff (!reset_n)
		timer1_overflow && t1_cnt == t1_last_two |-> t1_tick == rate_double_bit)
		else $error("rate doubling wrong");

	chk_reserved_zero: assert property (
		@(posedge clk) disable iff (!reset_n)
		setup && paddr == ctrl_offset |=> prdata[6:3] == 4'h0)
		else $error("reserved control bits nonzero");

	chk_pair_when_selected: assert property (
		@(posedge clk) disable iff (!reset_n)
		sel |=> tx_bit_tick == rx_bit_tick)
		else $error("tx and rx ticks split while selected");

	chk_tick_spacing: assert property (
		@(posedge clk) disable iff (!reset_n)
		t3_tick |=> !t3_tick)
		else $error("fractional ticks back to back");

	chk_prescale_hold: assert property (
		@(posedge clk) disable iff (!reset_n)
		!core_tick && !cfg_write |=> pre_cnt == $past(pre_cnt))
		else $error("prescaler moved without core tick");

	chk_prescale_bound: assert property (
		@(posedge clk) disable iff (!reset_n)
		pre_cnt <= pow2_mask(exponent))
		else $error("prescaler past its end count");

	chk_core_bound: assert property (
		@(posedge clk) disable iff (!reset_n)
		core_cnt <= pow2_mask(core_divide_setting))
		else $error("core divider past its end count");

	chk_reserved_held: assert property (
		@(posedge clk) disable iff (!reset_n)
		baud_timer_control[6:3] == 4'h0)
		else $error("reserved control bits stored");

endmodule // uart_fractional_baud_timer

// ==== sim/uart_shift_model.sv ====
// stand-in for the uart shift logic: counts bit ticks, times the tx gap
// assumes ticks are one-cycle pulses on clk
module uart_shift_model (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic tx_bit_tick,
	input  wire logic rx_bit_tick,
	input  wire logic baud_timer_select,
	output int        tx_count,
	output int        rx_count,
	output int        gap,
	output int        pair_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	int age;
	// the shifter only consumes ticks; it has no way to push back
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_count <= 0;
			rx_count <= 0;
			gap <= 0;
			age <= 0;
			pair_bad <= 0;
		end else begin
			age <= age + 1;
			if (tx_bit_tick === 1'b1) begin
				tx_count <= tx_count + 1;
				gap <= age + 1;
				age <= 0;
			end
			if (rx_bit_tick === 1'b1) begin
				rx_count <= rx_count + 1;
			end
			if (baud_timer_select === 1'b1 && tx_bit_tick !== rx_bit_tick) begin
				pair_bad <= pair_bad + 1;
			end
		end
	end
endmodule // uart_shift_model

// ==== sim/tb_top.sv ====
// self-checking bench for the fractional baud timer
// assumes zero-wait apb and the shift model beside the dut
module tb_top;
	import baud_timer_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, psel, penable, pwrite, t1o, t2o, rd, txs, rxs, noise;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, txt, rxt, sel;
	int tx_count, rx_count, gap, pair_bad, failures, checked, cycles;
	logic [4:0] rnd;
	localparam int core_hz = 125_000_000;
	uart_fractional_baud_timer i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer1_overflow(noise ? rnd[4] : t1o), .timer2_overflow(noise ? rnd[3] : t2o),
		.rate_double_bit(noise ? rnd[2] : rd), .timer2_tx_clk_sel(noise ? rnd[1] : txs),
		.timer2_rx_clk_sel(noise ? rnd[0] : rxs), .tx_bit_tick(txt), .rx_bit_tick(rxt),
		.baud_timer_select(sel));
	uart_shift_model i_model (.clk(clk), .reset_n(reset_n), .tx_bit_tick(txt), .rx_bit_tick(rxt),
		.baud_timer_select(sel), .tx_count(tx_count), .rx_count(rx_count), .gap(gap), .pair_bad(pair_bad));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bit period in clk cycles for core divide c, exponent x and fractional value f
	function automatic int bit_period(input int c, input int x, input int f);
		return ((1 << (c + x)) * (f + 64)) / 2;
	endfunction
	// software side: largest exponent with 32 * rate * 2^x not above the core rate
	function automatic int pick_exp(input int fc, input int rate);
		int x;
		x = 0;
		while (x < 7 && longint'(rate) * 64 * (longint'(1) << x) <= fc) x++;
		return x;
	endfunction
	// software side: fractional value rounded to nearest, less 64
	function automatic int pick_fdv(input int fc, input int rate, input int x);
		longint den;
		den = longint'(rate) << x;
		return int'((2 * longint'(fc) + den / 2) / den) - 64;
	endfunction
	// achieved rate within 0.8 percent (1/125) of the request
	function automatic bit rate_ok(input int fc, input int rate, input int period);
		longint err;
		err = longint'(fc) - longint'(rate) * period;
		if (err < 0) err = -err;
		return err * 125 <= longint'(rate) * period;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		chk("pready", 32'h1, {31'h0, pready});
		psel <= 0;
		penable <= 0;
	endtask
	// pulses one overflow every four cycles, returns pulses between two tx ticks
	task automatic pulse_gap(input logic use_t2, output int g);
		int first, prev;
		first = -1;
		prev = tx_count;
		g = 0;
		for (int i = 0; i < 80 && g == 0; i++) begin
			if (use_t2) t2o <= 1;
			else t1o <= 1;
			@(posedge clk);
			t1o <= 0;
			t2o <= 0;
			repeat (3) @(posedge clk);
			if (tx_count != prev) begin
				prev = tx_count;
				if (first < 0) first = i;
				else g = i - first;
			end
		end
	endtask
	task automatic wait_tx(input int n);
		int s0, m;
		s0 = tx_count;
		m = 0;
		while (tx_count < s0 + n && m < 12000) begin
			@(posedge clk);
			m++;
		end
		chk("tx ticks", s0 + n, tx_count);
	endtask
	// classic inputs wander at random while the dedicated timer is in charge
	always @(posedge clk) begin
		if (noise) rnd <= 5'($urandom);
		cycles++;
		if (cycles > 60000) begin
			failures++;
			$display("CHECK FAILED timeout expected %0d seen %0d", 60000, cycles);
			report_and_stop();
		end
	end
	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		logic [31:0] r;
		logic er;
		int s, g, tx0, rx0, c, x, f, tr;
		{reset_n, psel, penable, pwrite, t1o, t2o, rd, txs, rxs, noise} = '0;
		{paddr, pwdata, cycles, failures, checked, rnd} = '0;
		s = $urandom(84);
		repeat (6) @(posedge clk);
		reset_n <= 1;
		repeat (2) @(posedge clk);
		apb(0, ctrl_offset, 0, r, er);
		chk("ctrl reset", {24'h0, ctrl_reset}, r);
		apb(0, status_offset, 0, r, er);
		chk("status reset select", 32'h0, {31'h0, r[status_select_bit]});
		chk("status upper", 32'h0, r & 32'hFFFE_FE00);
		chk("status acc range", 32'h1, {31'h0, r[8:0] < fd_base});
		apb(0, 8'h10, 0, r, er);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, r);
		$display("test map done");
		for (int k = 0; k < 3; k++) begin
			rd <= (k == 1);
			txs <= (k == 2);
			rxs <= (k == 2);
			tx0 = tx_count;
			rx0 = rx_count;
			pulse_gap(k == 2, g);
			chk("classic select", 32'h0, {31'h0, sel});
			chk("classic gap", (k == 0) ? 32 : 16, g);
			chk("classic rx count", tx_count - tx0, rx_count - rx0);
		end
		$display("test classic done");
		apb(1, ctrl_offset, 32'hFF, r, er);
		apb(0, ctrl_offset, 0, r, er);
		chk("ctrl loose bits", 32'h87, r);
		apb(0, status_offset, 0, r, er);
		chk("status select", 32'h1, {31'h0, r[status_select_bit]});
		chk("select out", 32'h1, {31'h0, sel});
		for (int k = 0; k < 7; k++) begin
			c = (k == 0) ? 0 : $urandom % 2;
			x = (k == 0) ? 0 : $urandom % 3;
			f = (k == 0) ? 0 : ($urandom % 32) * 2;
			apb(1, clkctl_offset, c, r, er);
			apb(1, fdv_offset, f, r, er);
			apb(1, ctrl_offset, 32'h80 | x, r, er);
			noise <= 1;
			wait_tx(3);
			chk("bit period", bit_period(c, x, f), gap);
			noise <= 0;
		end
		for (int k = 0; k < 2; k++) begin
			tr = (k == 0) ? 115200 : 38400;
			x = pick_exp(core_hz, tr);
			f = pick_fdv(core_hz, tr, x);
			apb(1, clkctl_offset, 0, r, er);
			apb(1, fdv_offset, f, r, er);
			apb(1, ctrl_offset, 32'h80 | x, r, er);
			noise <= 1;
			wait_tx(3);
			chk("target period", bit_period(0, x, f), gap);
			chk("rate error", 32'h1, {31'h0, rate_ok(core_hz, tr, gap)});
			noise <= 0;
		end
		chk("tx rx paired", 32'h0, pair_bad);
		$display("test fractional done");
		report_and_stop();
	end
endmodule // tb_top
